/* File: verilog/ssr_status_top.sv */
`timescale 1ns/1ps
module ssr_status_top
    import ssr_pkg::*;
#(
    parameter int STATE_W = STATE_W_DEF,
    parameter int SLOTS   = SLOTS_DEF
)(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                cmd_valid,
    input  wire ssr_cmd_e            cmd_code,
    input  wire logic [7:0]          cmd_arg,
    input  wire logic                ops_pending,
    input  wire logic                oper_summary,
    input  wire logic [7:0]          event_set,
    input  wire logic                oq_read,
    input  wire logic [STATE_W-1:0]  live_state,
    output logic                     resp_valid,
    output logic [7:0]               resp_data,
    output logic                     msg_available,
    output logic [7:0]               status_byte,
    output logic                     service_request,
    output logic                     output_enable,
    output logic                     restore_valid,
    output logic [STATE_W-1:0]       restore_state,
    output logic                     sys_reset
);

    localparam int SLOT_AW = (SLOTS > 1) ? $clog2(SLOTS) : 1;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    function automatic logic cmd_is(input logic     v,
                                    input ssr_cmd_e code,
                                    input ssr_cmd_e want);
        return v && (code == want);
    endfunction

    logic                cls_any;
    logic                cls_nl;
    logic                sav_cmd;
    logic                rcl_cmd;
    logic                abort_cmd;
    logic [SLOT_AW-1:0]  slot;

    assign cls_nl    = cmd_is(cmd_valid, cmd_code, CMD_CLS_NL);
    assign cls_any   = cls_nl || cmd_is(cmd_valid, cmd_code, CMD_CLS);
    assign sav_cmd   = cmd_is(cmd_valid, cmd_code, CMD_SAV);
    assign rcl_cmd   = cmd_is(cmd_valid, cmd_code, CMD_RCL);
    assign abort_cmd = cmd_is(cmd_valid, cmd_code, CMD_ABORT);
    assign slot      = cmd_arg[SLOT_AW-1:0];

    // ------------------------------------------------------------
    // Standard event structure
    // ------------------------------------------------------------
    ssr_evt_if evi ();

    ssr_event_reg u_event (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ev      (evi.evt)
    );

    logic opc_cmd_wait;
    logic opc_cmd_done;

    assign opc_cmd_done = opc_cmd_wait && !ops_pending;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            opc_cmd_wait <= 1'b0;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_OPC)) begin
            opc_cmd_wait <= 1'b1;
        end else if (opc_cmd_done) begin
            opc_cmd_wait <= 1'b0;
        end
    end

    always_comb begin
        evi.ese_wr   = cmd_is(cmd_valid, cmd_code, CMD_ESE_WR);
        evi.ese_data = cmd_arg;
        evi.esr_clr  = cls_any || cmd_is(cmd_valid, cmd_code, CMD_ESR_QRY);
        evi.evt_set  = event_set;
        evi.evt_set[ESR_OPC_BIT] = event_set[ESR_OPC_BIT] || opc_cmd_done;
    end

    // ------------------------------------------------------------
    // Service request enable mask
    // ------------------------------------------------------------
    logic [7:0] sre;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sre <= SRE_RESET;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_SRE_WR)) begin
            sre <= cmd_arg;
        end
    end

    // ------------------------------------------------------------
    // Status byte
    // ------------------------------------------------------------
    logic [7:0] stb_base;
    logic       mss;
    logic [7:0] stb_now;

    always_comb begin
        stb_base               = 8'h00;
        stb_base[STB_OPER_BIT] = oper_summary;
        stb_base[STB_ESB_BIT]  = evi.esb;
        stb_base[STB_MAV_BIT]  = msg_available;
        mss                    = ssr_summary(stb_base, sre);
        stb_now                = stb_base & ~STB_LOW_MASK;
        stb_now[STB_MSS_BIT]   = mss;
    end

    // Register follows sources only; reads never touch it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_byte     <= STB_RESET;
            service_request <= 1'b0;
        end else begin
            status_byte     <= stb_now;
            service_request <= mss;
        end
    end

    // ------------------------------------------------------------
    // Operation-complete query
    // ------------------------------------------------------------
    ssr_opc_e opc_state;
    logic     opc_qry_done;

    assign opc_qry_done = (opc_state == OPC_WAIT) && !ops_pending;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            opc_state <= OPC_IDLE;
        end else begin
            case (opc_state)
                OPC_IDLE: begin
                    if (cmd_is(cmd_valid, cmd_code, CMD_OPC_QRY)) begin
                        opc_state <= OPC_WAIT;
                    end
                end
                OPC_WAIT: begin
                    if (!ops_pending) begin
                        opc_state <= OPC_IDLE;
                    end
                end
                default: opc_state <= OPC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Responses and output queue
    // ------------------------------------------------------------
    logic       next_resp_valid;
    logic [7:0] next_resp_data;

    always_comb begin
        next_resp_valid = 1'b0;
        next_resp_data  = resp_data;
        if (opc_qry_done) begin
            next_resp_valid = 1'b1;
            next_resp_data  = OPC_ASCII_ONE;
        end else if (cmd_valid) begin
            case (cmd_code)
                CMD_ESE_QRY: begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = evi.ese;
                end
                CMD_ESR_QRY: begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = evi.esr;
                end
                CMD_SRE_QRY: begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = sre;
                end
                CMD_STB_QRY: begin
                    next_resp_valid = 1'b1;
                    next_resp_data  = stb_now;
                end
                default: next_resp_valid = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_data  <= 8'h00;
        end else begin
            resp_valid <= next_resp_valid;
            resp_data  <= next_resp_data;
        end
    end

    // A new answer wins over a read or a clear in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msg_available <= 1'b0;
        end else if (next_resp_valid) begin
            msg_available <= 1'b1;
        end else if (oq_read || cls_nl) begin
            msg_available <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Save and recall of operating state
    // ------------------------------------------------------------
    logic [STATE_W-1:0] state_mem [SLOTS];

    always_ff @(posedge ref_clk) begin
        if (sav_cmd) begin
            state_mem[slot] <= live_state;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            restore_valid <= 1'b0;
            restore_state <= '0;
        end else begin
            restore_valid <= rcl_cmd;
            if (rcl_cmd) begin
                restore_state <= state_mem[slot];
            end
        end
    end

    // ------------------------------------------------------------
    // Output state, abort and system reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            output_enable <= 1'b0;
        end else if (abort_cmd || cmd_is(cmd_valid, cmd_code, CMD_RST)) begin
            output_enable <= 1'b0;
        end else if (cmd_is(cmd_valid, cmd_code, CMD_OUT_ON)) begin
            output_enable <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sys_reset <= 1'b0;
        end else begin
            sys_reset <= cmd_is(cmd_valid, cmd_code, CMD_RST);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_opc_ask;
        opc_state == OPC_IDLE && cmd_is(cmd_valid, cmd_code, CMD_OPC_QRY)
        ##1 !ops_pending;
    endsequence

    sequence s_sre_write_read;
        cmd_is(cmd_valid, cmd_code, CMD_SRE_WR)
        ##2 cmd_is(cmd_valid, cmd_code, CMD_SRE_QRY);
    endsequence

    sequence s_save_recall;
        sav_cmd ##2 rcl_cmd && slot == $past(slot, 2);
    endsequence

    chk_opc_answer_one: assert property (
        s_opc_ask |=> resp_valid && resp_data == OPC_ASCII_ONE)
        else $error("operation complete answer wrong");

    chk_opc_waits_busy: assert property (
        opc_state == OPC_WAIT && ops_pending |=> opc_state == OPC_WAIT)
        else $error("operation complete answered while busy");

    chk_sre_round_trip: assert property (
        s_sre_write_read |=> resp_valid && resp_data == $past(cmd_arg, 3))
        else $error("mask query does not return written mask");

    chk_mss_summary: assert property (
        status_byte[STB_MSS_BIT] == |({status_byte[7], 1'b0,
                                        status_byte[5:4], 4'h0}
                                       & $past(sre)))
        else $error("master summary does not match enabled bits");

    chk_low_bits_zero: assert property (
        (status_byte & STB_LOW_MASK) == 8'h00)
        else $error("status byte low bits not zero");

    chk_stb_query_value: assert property (
        opc_state == OPC_IDLE && cmd_is(cmd_valid, cmd_code, CMD_STB_QRY)
        |=> resp_valid && resp_data == status_byte)
        else $error("status byte query value wrong");

    chk_summary_sources: assert property (
        status_byte[STB_OPER_BIT] == $past(oper_summary)
        && status_byte[STB_ESB_BIT] == $past(evi.esb))
        else $error("summary bit does not follow its source");

    chk_mav_follow: assert property (
        (resp_valid |-> msg_available)
        and (oq_read && !next_resp_valid |=> !msg_available))
        else $error("message available bit wrong");

    chk_cls_nl_queue: assert property (
        cls_nl && !next_resp_valid |=> !msg_available)
        else $error("clear status with newline kept message bit");

    chk_abort_off: assert property (
        abort_cmd |=> !output_enable [*2])
        else $error("abort did not turn outputs off");

    chk_save_recall: assert property (
        s_save_recall |=> restore_valid
                          && restore_state == $past(live_state, 3))
        else $error("recalled state differs from saved state");

endmodule // ssr_status_top

/* File: pkg/ssr_pkg.sv */
package ssr_pkg;

    localparam int          STB_OPER_BIT   = 7;
    localparam int          STB_MSS_BIT    = 6;
    localparam int          STB_ESB_BIT    = 5;
    localparam int          STB_MAV_BIT    = 4;
    localparam logic [7:0]  STB_LOW_MASK   = 8'h0F;
    localparam int          ESR_OPC_BIT    = 0;
    localparam logic [7:0]  OPC_ASCII_ONE  = 8'h31;
    localparam logic [7:0]  SRE_RESET      = 8'h00;
    localparam logic [7:0]  ESE_RESET      = 8'h00;
    localparam logic [7:0]  ESR_RESET      = 8'h00;
    localparam logic [7:0]  STB_RESET      = 8'h00;
    localparam int          STATE_W_DEF    = 32;
    localparam int          SLOTS_DEF      = 4;

    typedef enum logic [3:0] {
        CMD_CLS,
        CMD_CLS_NL,
        CMD_ESE_WR,
        CMD_ESE_QRY,
        CMD_ESR_QRY,
        CMD_OPC,
        CMD_OPC_QRY,
        CMD_RCL,
        CMD_RST,
        CMD_SAV,
        CMD_SRE_WR,
        CMD_SRE_QRY,
        CMD_STB_QRY,
        CMD_ABORT,
        CMD_OUT_ON
    } ssr_cmd_e;

    typedef enum logic [0:0] {
        OPC_IDLE,
        OPC_WAIT
    } ssr_opc_e;

    // Summary of a byte under its enable mask
    function automatic logic ssr_summary(input logic [7:0] v,
                                         input logic [7:0] m);
        return |(v & m);
    endfunction

endpackage

/* File: pkg/ssr_evt_if.sv */
`timescale 1ns/1ps
interface ssr_evt_if;
    logic        ese_wr;
    logic [7:0]  ese_data;
    logic        esr_clr;
    logic [7:0]  evt_set;
    logic [7:0]  ese;
    logic [7:0]  esr;
    logic        esb;

    modport ctl (output ese_wr, ese_data, esr_clr, evt_set,
                 input  ese, esr, esb);
    modport evt (input  ese_wr, ese_data, esr_clr, evt_set,
                 output ese, esr, esb);
endinterface

/* File: verilog/ssr_event_reg.sv */
`timescale 1ns/1ps
module ssr_event_reg
    import ssr_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  rst,
    ssr_evt_if.evt     ev
);

    // ------------------------------------------------------------
    // Event enable and event register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev.ese <= ESE_RESET;
        end else if (ev.ese_wr) begin
            ev.ese <= ev.ese_data;
        end
    end

    // New events win over the clear of the read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev.esr <= ESR_RESET;
        end else begin
            ev.esr <= (ev.esr_clr ? ESR_RESET : ev.esr) | ev.evt_set;
        end
    end

    assign ev.esb = ssr_summary(ev.esr, ev.ese);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_esr_read_clear: assert property (
        ev.esr_clr && ev.evt_set == 8'h00 |=> ev.esr == 8'h00)
        else $error("event register not cleared by read");

    chk_esr_set_wins: assert property (
        ev.evt_set[ESR_OPC_BIT] |=> ev.esr[ESR_OPC_BIT])
        else $error("event lost against clear");

endmodule // ssr_event_reg

/* File: tb/ssr_ctl_model.sv */
`timescale 1ns/1ps
module ssr_ctl_model
    import ssr_pkg::*;
(
    input  wire logic        ref_clk,
    output ssr_cmd_e         cmd_code,
    output logic             cmd_valid,
    output logic [7:0]       cmd_arg,
    output logic             oq_read,
    input  wire logic        resp_valid,
    input  wire logic [7:0]  resp_data
);
    // ------------------------------------------------------------
    // Controller side of the command port
    // ------------------------------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = CMD_CLS;
        cmd_arg   = 8'h00;
        oq_read   = 1'b0;
    end

    // One command, argument held to the taking edge, then scrambled
    task automatic send(input ssr_cmd_e c, input logic [7:0] a);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_arg   <= a;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_arg   <= ~a;
    endtask

    // Bounded wait for an answer, optional read-out of the queue
    task automatic wait_resp(input logic rd, output logic [7:0] d);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (resp_valid !== 1'b1 && n < 200);
        d = (resp_valid === 1'b1) ? resp_data : 8'hxx;
        if (rd) begin
            oq_read <= 1'b1;
            @(posedge ref_clk);
            oq_read <= 1'b0;
        end
    endtask

    task automatic query(input ssr_cmd_e c, input logic rd,
                         output logic [7:0] d);
        send(c, 8'h00);
        wait_resp(rd, d);
    endtask
endmodule // ssr_ctl_model

/* File: tb/ssr_status_top_tb.sv */
`timescale 1ns/1ps
module ssr_status_top_tb
    import ssr_pkg::*;
;
    logic         ref_clk;
    logic         rst;
    logic         cmd_valid;
    ssr_cmd_e     cmd_code;
    logic [7:0]   cmd_arg;
    logic         ops_pending;
    logic         oper_summary;
    logic [7:0]   event_set;
    logic         oq_read;
    logic [31:0]  live_state;
    logic         resp_valid;
    logic [7:0]   resp_data;
    logic         msg_available;
    logic [7:0]   status_byte;
    logic         service_request;
    logic         output_enable;
    logic         restore_valid;
    logic [31:0]  restore_state;
    logic         sys_reset;
    logic [7:0]   d;
    logic         seen;
    int           error_cnt = 0;
    int           n_checks = 0;
    int           cyc = 0;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    ssr_status_top #(.STATE_W(32), .SLOTS(4)) u_ssr_status_top (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg),
        .ops_pending(ops_pending), .oper_summary(oper_summary),
        .event_set(event_set), .oq_read(oq_read),
        .live_state(live_state), .resp_valid(resp_valid),
        .resp_data(resp_data), .msg_available(msg_available),
        .status_byte(status_byte), .service_request(service_request),
        .output_enable(output_enable), .restore_valid(restore_valid),
        .restore_state(restore_state), .sys_reset(sys_reset));

    ssr_ctl_model u_ssr_ctl_model (
        .ref_clk(ref_clk), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
        .cmd_arg(cmd_arg), .oq_read(oq_read), .resp_valid(resp_valid),
        .resp_data(resp_data));

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] sv, input logic [31:0] ex);
        n_checks++;
        if (sv !== ex) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, ex);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic s(input ssr_cmd_e c, input logic [7:0] a);
        u_ssr_ctl_model.send(c, a);
    endtask

    task automatic q(input ssr_cmd_e c, input logic rd);
        u_ssr_ctl_model.query(c, rd, d);
    endtask

    task automatic rcl(input logic [7:0] slot, input logic [31:0] ex);
        s(CMD_RCL, slot);
        @(posedge ref_clk);
        chk(restore_valid, 1'b1);
        chk(restore_state, ex);
    endtask

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst          = 1'b1;
        ops_pending  = 1'b0;
        oper_summary = 1'b0;
        event_set    = 8'h00;
        live_state   = 32'h0000_0000;
        tick(8);
        rst <= 1'b0;
        tick(1);
        chk(status_byte, 8'h00);
        chk(output_enable, 1'b0);
        q(CMD_SRE_QRY, 1'b1);
        chk(d, 8'h00);
        done("reset");

        s(CMD_SRE_WR, 8'hFF);
        q(CMD_SRE_QRY, 1'b1);
        chk(d, 8'hFF);
        s(CMD_SRE_WR, 8'h00);
        q(CMD_SRE_QRY, 1'b1);
        chk(d, 8'h00);
        oper_summary <= 1'b1;
        tick(3);
        q(CMD_STB_QRY, 1'b0);
        chk(d, 8'h80);
        tick(3);
        chk(msg_available, 1'b1);
        chk(status_byte, 8'h90);
        s(CMD_SRE_WR, 8'h10);
        tick(3);
        chk(service_request, 1'b1);
        chk(status_byte, 8'hD0);
        q(CMD_STB_QRY, 1'b1);
        chk(d, 8'hD0);
        tick(3);
        chk(status_byte, 8'h80);
        q(CMD_STB_QRY, 1'b0);
        s(CMD_CLS_NL, 8'h00);
        tick(3);
        chk(msg_available, 1'b0);
        chk(status_byte, 8'h80);
        oper_summary <= 1'b0;
        done("status");

        s(CMD_SRE_WR, 8'h20);
        s(CMD_ESE_WR, 8'h01);
        event_set <= 8'hFE;
        tick(1);
        event_set <= 8'h00;
        tick(3);
        chk(status_byte, 8'h00);
        s(CMD_ESE_WR, 8'hFE);
        tick(3);
        chk(status_byte, 8'h60);
        q(CMD_ESE_QRY, 1'b1);
        chk(d, 8'hFE);
        q(CMD_ESR_QRY, 1'b1);
        chk(d, 8'hFE);
        tick(3);
        chk(status_byte, 8'h00);
        q(CMD_ESR_QRY, 1'b1);
        chk(d, 8'h00);
        s(CMD_ESE_WR, 8'h01);
        ops_pending <= 1'b1;
        s(CMD_OPC, 8'h00);
        tick(6);
        chk(status_byte, 8'h00);
        ops_pending <= 1'b0;
        tick(4);
        chk(status_byte, 8'h60);
        q(CMD_ESR_QRY, 1'b1);
        chk(d, 8'h01);
        q(CMD_STB_QRY, 1'b0);
        chk(d, 8'h00);
        s(CMD_CLS, 8'h00);
        tick(3);
        chk(msg_available, 1'b1);
        s(CMD_CLS_NL, 8'h00);
        done("events");

        ops_pending <= 1'b1;
        s(CMD_OPC_QRY, 8'h00);
        seen = 1'b0;
        repeat (10) begin
            @(posedge ref_clk);
            if (resp_valid === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b0);
        ops_pending <= 1'b0;
        u_ssr_ctl_model.wait_resp(1'b1, d);
        chk(d, 8'h31);
        q(CMD_OPC_QRY, 1'b1);
        chk(d, 8'h31);
        done("opc_query");

        live_state <= 32'hA5A5_0001;
        s(CMD_SAV, 8'h01);
        live_state <= 32'h5A5A_0002;
        s(CMD_SAV, 8'h02);
        live_state <= 32'hFFFF_0000;
        rcl(8'h02, 32'h5A5A_0002);
        rcl(8'h01, 32'hA5A5_0001);
        done("save_recall");

        s(CMD_OUT_ON, 8'h00);
        tick(2);
        chk(output_enable, 1'b1);
        s(CMD_ABORT, 8'h00);
        @(posedge ref_clk);
        chk(output_enable, 1'b0);
        s(CMD_OUT_ON, 8'h00);
        s(CMD_RST, 8'h00);
        @(posedge ref_clk);
        chk(output_enable, 1'b0);
        chk(sys_reset, 1'b1);
        done("abort");

        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk(status_byte, 8'h00);
        q(CMD_SRE_QRY, 1'b1);
        chk(d, 8'h00);
        done("second_reset");
        finish_test();
    end
endmodule // ssr_status_top_tb
